// >>> hdl/tpl_probe_latch.v
// two-channel touch-probe position latch with an AXI4-Lite register slave.
// assumes position, probe inputs and index pulse are synchronous to aclk.
`timescale 1ns/1ps
`include "tpl_map.vh"

// ==========================================================
// overview for the next engineer
//
// register map (word index, byte address is four times it):
//   control word         rw, 16 bits, per-probe byte
//   status word          ro, 16 bits, per-probe byte
//   four result words    ro, position taken at each capture
//   four count words     ro, captures since the last control change
//   irq status           w1c, one bit per probe and edge
//   irq mask             rw, same layout as irq status
//
// control byte layout (probe 2 sits eight bits higher):
//   bit 0  enable
//   bit 1  mode, 0 single, 1 continuous
//   bit 2  source, 0 external pin, 1 encoder index
//   bit 4  rising edge trigger enable
//   bit 5  falling edge trigger enable
//
// status byte layout:
//   bit 0  probe enabled
//   bit 1  rising capture executed
//   bit 2  falling capture executed
//
// capture timing:
//   the selected line is compared with its value one cycle earlier;
//   an edge seen in cycle n latches the position of cycle n at edge n+1,
//   bumps the matching counter and sets the matching flag and irq bit.
//   inputs are taken as already synchronous: a raw pin needs its own
//   synchroniser outside this block, or edges may be lost or doubled.
//
// single mode:
//   enabling arms the probe; the first accepted edge disarms it.
//   software re-arms by clearing and then setting the enable bit.
//   with both edges enabled only the rising edge is honoured, so a
//   falling edge never steals the single shot.
//
// control writes:
//   a write that changes the word restarts all four counters; the
//   write wins over a capture in the same cycle, so a count never
//   carries over into the new setting. rewriting the same value has no
//   effect at all. disabling a probe clears its executed flags; result
//   positions are kept so software can still read the last capture.
//   an edge present in the cycle the enable is written is not taken,
//   because the written control word only takes effect one cycle later.
//
// bus timing:
//   each ready is a one-cycle pulse, raised the cycle after valid is
//   seen, so every item is taken exactly once. the write runs the edge
//   after both address and data are held; bvalid follows on that edge.
//   reads sample the register on the edge the address is taken and
//   answer one cycle later. no new write item is taken while a write
//   response waits, and no new read while read data waits.
//   unmapped reads answer slverr with zero data; writes to read-only
//   or unmapped words answer slverr and change nothing.
//
// clock enable:
//   clk_en low freezes every register, the bus handshakes included;
//   a master must not count cycles across a frozen stretch.
//
// limits:
//   counters wrap silently at the top of their 32-bit range.
//   positions are plain snapshots; no compensation time is applied.
//

module tpl_probe_latch
(
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [31:0] position,
  input wire probe_input_one,
  input wire probe_input_two,
  input wire encoder_index,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq
);

  // ==========================================================
  // state
  reg [15:0] ctrl;
  reg [1:0] rdone;
  reg [1:0] fdone;
  reg [1:0] armed;
  reg [1:0] trig_prev;
  reg [31:0] pos_r [0:3];
  reg [31:0] cnt_r [0:3];
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [17:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // decode a byte address into a register index, ignoring the low two bits
  function [15:0] word_index;
    input [17:0] addr;
    begin
      word_index = addr[17:2];
    end
  endfunction

  // ==========================================================
  // trigger selection and edge detection
  wire [1:0] trig_now;
  wire [1:0] rise_ok;
  wire [1:0] fall_ok;
  wire do_write;
  wire [15:0] widx;
  wire [15:0] next_ctrl;
  wire ctrl_changed;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign widx = word_index(aw_addr);
  // byte lanes 0 and 1 carry the 16-bit control word
  assign next_ctrl = {w_strb[1] ? w_data[15:8] : ctrl[15:8],
                      w_strb[0] ? w_data[7:0] : ctrl[7:0]};
  assign ctrl_changed = do_write && (widx == `TPL_IDX_CTRL) && (next_ctrl != ctrl);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_probe
      wire ext_in;
      wire en;
      wire cont;
      assign ext_in = (g == 0) ? probe_input_one : probe_input_two;
      // source select: external pin or encoder index
      assign trig_now[g] = ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_SRC] ? encoder_index : ext_in;
      assign en = ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_EN];
      assign cont = ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_MODE];
      // rising edge gated by enable, rising bit and arm state
      assign rise_ok[g] = en && (cont || armed[g]) &&
                          ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_RISE] &&
                          trig_now[g] && !trig_prev[g];
      // in single mode a falling edge counts only if rising is off
      assign fall_ok[g] = en && (cont || (armed[g] &&
                          !ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_RISE])) &&
                          ctrl[g*`TPL_PROBE_STRIDE+`TPL_CF_FALL] &&
                          !trig_now[g] && trig_prev[g];
    end
  endgenerate

  // ==========================================================
  // capture, counters, arm state and executed flags
  integer i;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `TPL_CTRL_RST;
      rdone <= 2'b00;
      fdone <= 2'b00;
      armed <= 2'b00;
      trig_prev <= 2'b00;
      for (i = 0; i < 4; i = i + 1)
      begin
        pos_r[i] <= 32'h0000_0000;
        cnt_r[i] <= 32'h0000_0000;
      end
    end
    else if (clk_en)
    begin
      trig_prev <= trig_now;
      for (i = 0; i < 2; i = i + 1)
      begin
        // a capture in single mode disarms until the enable is toggled
        if (rise_ok[i] || fall_ok[i])
          armed[i] <= 1'b0;
        if (rise_ok[i])
        begin
          pos_r[2*i] <= position;
          cnt_r[2*i] <= cnt_r[2*i] + 32'h0000_0001;
          rdone[i] <= 1'b1;
        end
        if (fall_ok[i])
        begin
          pos_r[2*i+1] <= position;
          cnt_r[2*i+1] <= cnt_r[2*i+1] + 32'h0000_0001;
          fdone[i] <= 1'b1;
        end
      end
      if (ctrl_changed)
      begin
        ctrl <= next_ctrl;
        for (i = 0; i < 2; i = i + 1)
        begin
          // the write wins over a same-cycle capture: counts restart from zero
          cnt_r[2*i] <= 32'h0000_0000;
          cnt_r[2*i+1] <= 32'h0000_0000;
          // re-arm on a 0 -> 1 enable transition
          if (next_ctrl[i*`TPL_PROBE_STRIDE+`TPL_CF_EN] &&
              !ctrl[i*`TPL_PROBE_STRIDE+`TPL_CF_EN])
            armed[i] <= 1'b1;
          // disabling drops the executed flags
          if (!next_ctrl[i*`TPL_PROBE_STRIDE+`TPL_CF_EN])
          begin
            armed[i] <= 1'b0;
            rdone[i] <= 1'b0;
            fdone[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // status word view
  wire [15:0] stat_word;
  assign stat_word = {5'h00, fdone[1], rdone[1], ctrl[8],
                      5'h00, fdone[0], rdone[0], ctrl[0]};

  // ==========================================================
  // interrupt: one sticky bit per capture event, write one to clear
  wire [3:0] cap_evt;
  wire [3:0] irq_clr;
  assign cap_evt = {fall_ok[1], rise_ok[1], fall_ok[0], rise_ok[0]};
  assign irq_clr = (do_write && widx == `TPL_IDX_IRQ_STAT && w_strb[0]) ?
                   w_data[3:0] : 4'h0;

  // set beats clear so an event in the clearing cycle survives
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat <= (irq_stat & ~irq_clr) | cap_evt;
      if (do_write && widx == `TPL_IDX_IRQ_MASK && w_strb[0])
        irq_mask <= w_data[3:0];
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // axi4-lite write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPL_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 18'h00000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (clk_en)
    begin
      // ready is a one-cycle pulse so each item is taken exactly once
      // nothing new is taken while a write response still waits
      s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only control, interrupt status and mask are writable
        if (widx == `TPL_IDX_CTRL || widx == `TPL_IDX_IRQ_STAT ||
            widx == `TPL_IDX_IRQ_MASK)
          s_axi_bresp <= `TPL_RESP_OKAY;
        else
          s_axi_bresp <= `TPL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  reg [31:0] rd_val;
  reg rd_hit;
  wire [15:0] ridx;
  assign ridx = word_index(s_axi_araddr);

  // read mux; narrow registers sit in the low bits
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ridx == `TPL_IDX_CTRL)
      rd_val = {16'h0000, ctrl};
    else if (ridx == `TPL_IDX_STAT)
      rd_val = {16'h0000, stat_word};
    else if (ridx == `TPL_IDX_P1R_POS)
      rd_val = pos_r[0];
    else if (ridx == `TPL_IDX_P1F_POS)
      rd_val = pos_r[1];
    else if (ridx == `TPL_IDX_P2R_POS)
      rd_val = pos_r[2];
    else if (ridx == `TPL_IDX_P2F_POS)
      rd_val = pos_r[3];
    else if (ridx == `TPL_IDX_P1R_CNT)
      rd_val = cnt_r[0];
    else if (ridx == `TPL_IDX_P1F_CNT)
      rd_val = cnt_r[1];
    else if (ridx == `TPL_IDX_P2R_CNT)
      rd_val = cnt_r[2];
    else if (ridx == `TPL_IDX_P2F_CNT)
      rd_val = cnt_r[3];
    else if (ridx == `TPL_IDX_IRQ_STAT)
      rd_val = {28'h0000000, irq_stat};
    else if (ridx == `TPL_IDX_IRQ_MASK)
      rd_val = {28'h0000000, irq_mask};
    else
      rd_hit = 1'b0;
  end

  // data is sampled when the address is taken, one answer at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TPL_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `TPL_RESP_OKAY : `TPL_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> hdl/tpl_map.vh
// register offsets, field positions and reset values of the touch-probe latch.
// assumes AXI4-Lite byte addressing; printed offsets are word indices.
`ifndef TPL_MAP_VH
`define TPL_MAP_VH

// ==========================================================
// register indices (byte address is four times the index)
`define TPL_IDX_CTRL 16'h60b8
`define TPL_IDX_STAT 16'h60b9
`define TPL_IDX_P1R_POS 16'h60ba
`define TPL_IDX_P1F_POS 16'h60bb
`define TPL_IDX_P2R_POS 16'h60bc
`define TPL_IDX_P2F_POS 16'h60bd
`define TPL_IDX_P1R_CNT 16'h60d5
`define TPL_IDX_P1F_CNT 16'h60d6
`define TPL_IDX_P2R_CNT 16'h60d7
`define TPL_IDX_P2F_CNT 16'h60d8
`define TPL_IDX_IRQ_STAT 16'h6100
`define TPL_IDX_IRQ_MASK 16'h6101

// ==========================================================
// control word fields, per probe byte (probe 2 adds 8)
`define TPL_CF_EN 0
`define TPL_CF_MODE 1
`define TPL_CF_SRC 2
`define TPL_CF_RISE 4
`define TPL_CF_FALL 5
`define TPL_PROBE_STRIDE 8

// status word fields, per probe byte
`define TPL_SF_EN 0
`define TPL_SF_RDONE 1
`define TPL_SF_FDONE 2

// ==========================================================
// reset values and bus answers
`define TPL_CTRL_RST 16'h0000
`define TPL_RESP_OKAY 2'b00
`define TPL_RESP_SLVERR 2'b10

`endif

// >>> verification/tpl_bus_sva.sv
// bus-timing checker for the touch-probe latch register slave.
// assumes it sees only slave ports; the bench holds clk_en high throughout.
`timescale 1ns/1ps
module tpl_bus_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  // ====================================================
  // handshake timing
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a ready pulse answers a request seen one cycle earlier; an awready pulse also lasts one cycle
  a_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid) && !$past(s_axi_awready))
    else $error("awready without a pending write address");
  a_ar_cause: assert property (s_axi_arready |-> $past(s_axi_arvalid))
    else $error("arready without a pending read address");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // answers stand until taken, and block new requests meanwhile
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid))
    else $error("rvalid dropped before rready");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken with response pending");
  a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken with data pending");
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
endmodule

bind tpl_probe_latch tpl_bus_sva u_sva (.*);

// >>> verification/tpl_sensor_model.sv
// sensor-side model: two probe lines, the encoder index and the position feed.
// assumes the bench calls drive just after a rising edge of aclk.
`timescale 1ns/1ps
module tpl_sensor_model
(
  input wire logic aclk,
  output logic [31:0] position,
  output logic probe_input_one,
  output logic probe_input_two,
  output logic encoder_index
);
  // ====================================================
  // lines idle low, position parked at zero
  initial
  begin
    position = 32'h0;
    probe_input_one = 1'h0;
    probe_input_two = 1'h0;
    encoder_index = 1'h0;
  end
  // park the position, move one line, then let the position run on
  // so that a latch taken too late shows a wrong value
  task automatic drive(input logic [1:0] s, input logic l, input logic [31:0] p);
    position <= p;
    @(posedge aclk);
    case (s)
      2'h0: probe_input_one <= l;
      2'h1: probe_input_two <= l;
      default: encoder_index <= l;
    endcase
    repeat (4) @(posedge aclk);
    position <= ~p;
    @(posedge aclk);
  endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the touch-probe latch: a table of captures, then odd cases.
// assumes the sensor model feeds the probe lines and the position on aclk.
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [15:0] c; logic [1:0] s; logic l; logic [15:0] st;
    logic [15:0] ri; logic [31:0] re;} tpl_row_t;
  logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic aresetn = 1'h0, clk_en = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, position, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic probe_input_one, probe_input_two, encoder_index;
  int errors = 0, num_checks = 0, cyc = 0;
  tpl_row_t rows [14];

  // ====================================================
  // design, sensor model, clock, hang guard
  tpl_probe_latch dut (.*);
  tpl_sensor_model pm (.*);
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  // a stuck handshake ends the run well past the expected few hundred cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  // ====================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, g, e);
    end
  endtask
  // address and data offered together; each released when its ready is seen
  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [15:0] i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task results;
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ====================================================
  // main sequence
  initial
  begin
    // control word, line (0 one, 1 two, 2 index), level, status, register read, value
    rows = '{'{16'h0033, 2'h0, 1'h1, 16'h0003, 16'h60d5, 32'h1},
      '{16'h0033, 2'h0, 1'h0, 16'h0007, 16'h60bb, 32'h5a01},
      '{16'h3300, 2'h1, 1'h1, 16'h0300, 16'h60d5, 32'h0},
      '{16'h3300, 2'h1, 1'h0, 16'h0700, 16'h60bd, 32'h5a03},
      '{16'h3737, 2'h2, 1'h1, 16'h0703, 16'h60bc, 32'h5a04},
      '{16'h3737, 2'h2, 1'h0, 16'h0707, 16'h60d8, 32'h1},
      '{16'h0000, 2'h0, 1'h1, 16'h0000, 16'h60ba, 32'h5a04},
      '{16'h0011, 2'h0, 1'h0, 16'h0001, 16'h60bb, 32'h5a05},
      '{16'h0011, 2'h0, 1'h1, 16'h0003, 16'h60ba, 32'h5a08},
      '{16'h0011, 2'h0, 1'h0, 16'h0003, 16'h60d5, 32'h1},
      '{16'h0011, 2'h0, 1'h1, 16'h0003, 16'h60ba, 32'h5a08},
      '{16'h0010, 2'h0, 1'h0, 16'h0000, 16'h60d5, 32'h0}, // clear enable
      '{16'h0031, 2'h0, 1'h1, 16'h0003, 16'h60ba, 32'h5a0c}, // then set it
      '{16'h0031, 2'h0, 1'h0, 16'h0003, 16'h60bb, 32'h5a05}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[k])
    begin
      wr(16'h60b8, {16'h0, rows[k].c});
      pm.drive(rows[k].s, rows[k].l, 32'h5a00 + 32'(k));
      rd(16'h60b9);
      chk(d, {16'h0, rows[k].st});
      rd(rows[k].ri);
      chk(d, rows[k].re);
    end
    // flags stay hidden until unmasked; writing ones clears them
    chk({31'h0, irq}, 32'h0);
    wr(16'h6101, 32'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(16'h6100, 32'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // unmapped read, writes to read-only places are refused and change nothing
    rd(16'h7000);
    chk(d, 32'h0);
    chk({30'h0, resp}, 32'h2);
    wr(16'h60ba, 32'h1234);
    chk({30'h0, resp}, 32'h2);
    rd(16'h60ba);
    chk(d, 32'h5a0c);
    wr(16'h60b9, 32'hffff);
    rd(16'h60b9);
    chk(d, 32'h0003);
    // a second reset disables both probes and quiets irq
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(16'h60b8);
    chk(d, 32'h0);
    rd(16'h60b9);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule
